//--- board_regs.sv
// Board register block behind the bridge's board window.
// Assumes one write request per cycle at most and byte offsets.
`timescale 1ns/1ps
`default_nettype none

module board_regs (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  // request from bridge
  input  wire bridge_pkg::board_req_t req_i,
  output logic [7:0]                rdata_o,
  // board side
  input  wire logic [11:0][7:0]     port_in_i,
  input  wire logic [1:0][7:0]      counter_in_i,
  output logic [11:0][7:0]          port_out_o,
  output logic [1:0][7:0]           counter_load_o,
  output bridge_pkg::board_cfg_t    cfg_o,
  output logic                      irq_clear_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // interface n at 4n, ports 0..2 then mode; 4'hF marks no data port
  function automatic logic [3:0] port_slot(input logic [11:0] ofs);
    if (ofs[11:4] == 8'h00 && ofs[1:0] != bridge_pkg::IFACE_CFG_SLOT)
      return {2'b00, ofs[3:2]} * 4'h3 + {2'b00, ofs[1:0]};
    return 4'hF;
  endfunction

  wire logic [3:0] wr_slot  = port_slot(req_i.offset);
  wire logic [3:0] rd_slot  = port_slot(req_i.offset);
  wire logic       wr_counter_zero  = req_i.wr && req_i.offset == bridge_pkg::COUNTER_ZERO_OFS;
  wire logic       wr_ctr1  = req_i.wr && req_i.offset == bridge_pkg::CTR1_OFS;

  logic [7:0] counter_mode_r;
  logic [7:0] irq_one_r;
  logic [7:0] irq_two_r;
  logic       irq_clear_r;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < bridge_pkg::NUM_PORTS; i++) begin : g_port
    logic [7:0] data_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) data_r <= bridge_pkg::BOARD_REG_RESET;
      else if (req_i.wr && wr_slot == 4'(i)) data_r <= req_i.wdata;
    end
    assign port_out_o[i] = data_r;
  end

  for (genvar n = 0; n < bridge_pkg::NUM_IFACES; n++) begin : g_iface
    logic [7:0] mode_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) mode_r <= bridge_pkg::BOARD_REG_RESET;
      else if (req_i.wr && req_i.offset == 12'(4 * n + 3)) mode_r <= req_i.wdata;
    end
    assign cfg_o.iface_mode[n] = mode_r;
  end

  for (genvar k = 0; k < 2; k++) begin : g_ctr
    logic [7:0] load_r;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) load_r <= bridge_pkg::BOARD_REG_RESET;
      else if (k == 0 ? wr_counter_zero : wr_ctr1) load_r <= req_i.wdata;
    end
    assign counter_load_o[k] = load_r;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      counter_mode_r <= bridge_pkg::BOARD_REG_RESET;
      irq_one_r      <= bridge_pkg::BOARD_REG_RESET;
      irq_two_r      <= bridge_pkg::BOARD_REG_RESET;
      irq_clear_r    <= 1'b0;
    end else begin
      if (req_i.wr && req_i.offset == bridge_pkg::CTR_CFG_OFS)
        counter_mode_r <= req_i.wdata;
      if (req_i.wr && req_i.offset == bridge_pkg::IRQ_ONE_OFS)
        irq_one_r <= req_i.wdata;
      if (req_i.wr && req_i.offset == bridge_pkg::IRQ_TWO_OFS)
        irq_two_r <= req_i.wdata;
      irq_clear_r <= req_i.wr && req_i.offset == bridge_pkg::IRQ_CLR_OFS;
    end
  end

  // write-only registers read back as zero; ports read their pins
  assign rdata_o = (rd_slot != 4'hF) ? port_in_i[rd_slot] :
                   (req_i.offset == bridge_pkg::COUNTER_ZERO_OFS) ? counter_in_i[0] :
                   (req_i.offset == bridge_pkg::CTR1_OFS) ? counter_in_i[1] : 8'h00;

  assign cfg_o.counter_mode = counter_mode_r;
  assign cfg_o.irq_one      = irq_one_r;
  assign cfg_o.irq_two      = irq_two_r;
  assign irq_clear_o        = irq_clear_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  irq_clear_pulse_a: assert property (
    req_i.wr && req_i.offset == bridge_pkg::IRQ_CLR_OFS |=> irq_clear_o ##1 !irq_clear_o)
    else $error("clear write did not pulse the interrupt clear");
  irq_one_load_a: assert property (
    req_i.wr && req_i.offset == bridge_pkg::IRQ_ONE_OFS |=> cfg_o.irq_one == $past(req_i.wdata))
    else $error("first interrupt control register not loaded");
  counter_one_load_a: assert property (
    wr_ctr1 |=> counter_load_o[1] == $past(req_i.wdata) && $stable(counter_load_o[0]))
    else $error("counter one write went astray");
  port_b_iface_c_a: assert property (
    req_i.wr && req_i.offset == 12'h009 |=> port_out_o[7] == $past(req_i.wdata))
    else $error("interface C port B is not port seven");

endmodule // board_regs

`default_nettype wire

//--- bridge_pkg.sv
// Package: shared constants, field layouts and carrier types for the PCI
// board window bridge and its board register block.
// Assumes a 32-bit PCI target clocked by the bus clock.
`default_nettype none

package bridge_pkg;

  // ---------------------------------------------------------------
  // bus commands and configuration space
  // ---------------------------------------------------------------
  localparam logic [3:0]  CMD_MEM_RD       = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR       = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD       = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR       = 4'hB;
  localparam logic [7:0]  CFG_ID_OFS       = 8'h00;
  localparam logic [7:0]  CFG_CMD_OFS      = 8'h04;
  localparam logic [7:0]  CFG_BAR0_OFS     = 8'h10;
  localparam logic [7:0]  CFG_BAR1_OFS     = 8'h14;
  localparam int          CMD_MEM_EN_BIT   = 1;
  localparam logic [15:0] CMD_RESET        = 16'h0000;
  localparam int          WIN_ADDR_BITS    = 12;
  localparam logic [19:0] BAR_RESET        = 20'h00000;

  // ---------------------------------------------------------------
  // bridge window registers
  // ---------------------------------------------------------------
  localparam logic [11:0] BRG_WINDOW_OFS   = 12'h0C0;
  localparam logic [11:0] BRG_UNLOCK_OFS   = 12'h340;
  localparam logic [31:0] WINDOW_ADDR_MASK = 32'hFFFFFF00;
  localparam logic [31:0] WINDOW_EN_MASK   = 32'h00000080;
  localparam int          WINDOW_EN_BIT    = 7;
  localparam logic [31:0] WINDOW_RESET     = 32'h00000000;
  localparam logic [31:0] UNLOCK_KEY       = 32'h0000AEAE;

  // ---------------------------------------------------------------
  // board register map
  // ---------------------------------------------------------------
  localparam int          NUM_IFACES       = 4;
  localparam int          PORTS_PER_IFACE  = 3;
  localparam int          NUM_PORTS        = 12;
  localparam logic [1:0]  IFACE_CFG_SLOT   = 2'h3;
  localparam logic [11:0] COUNTER_ZERO_OFS         = 12'h010;
  localparam logic [11:0] CTR1_OFS         = 12'h011;
  localparam logic [11:0] CTR_CFG_OFS      = 12'h013;
  localparam logic [11:0] IRQ_ONE_OFS      = 12'h014;
  localparam logic [11:0] IRQ_TWO_OFS      = 12'h015;
  localparam logic [11:0] IRQ_CLR_OFS      = 12'h016;
  localparam logic [7:0]  BOARD_REG_RESET  = 8'h00;

  typedef struct packed {
    logic        wr;
    logic [11:0] offset;
    logic [7:0]  wdata;
  } board_req_t;

  typedef struct packed {
    logic [3:0][7:0] iface_mode;
    logic [7:0]      counter_mode;
    logic [7:0]      irq_one;
    logic [7:0]      irq_two;
  } board_cfg_t;

endpackage

`default_nettype wire

//--- pci_board_window_bridge.sv
// PCI target front end: configuration space, bridge window registers and
// forwarding of board-window memory accesses to the board register block.
// Assumes single-word target transfers; bursts are disconnected with data.
`timescale 1ns/1ps
`default_nettype none

module pci_board_window_bridge #(
  parameter logic [15:0] VENDOR_ID = 16'h5A5A,  // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0A0B   // arbitrary value
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  // pci address/data and control
  input  wire logic [31:0]          ad_i,
  output logic [31:0]               ad_o,
  output logic                      ad_oe_o,
  input  wire logic [3:0]           cbe_n_i,
  input  wire logic                 frame_n_i,
  input  wire logic                 irdy_n_i,
  input  wire logic                 idsel_i,
  output logic                      devsel_n_o,
  output logic                      devsel_oe_o,
  output logic                      trdy_n_o,
  output logic                      trdy_oe_o,
  output logic                      stop_n_o,
  output logic                      stop_oe_o,
  output logic                      par_o,
  output logic                      par_oe_o,
  // board side
  input  wire logic [11:0][7:0]     port_in_i,
  input  wire logic [1:0][7:0]      counter_in_i,
  output logic [11:0][7:0]          port_out_o,
  output logic [1:0][7:0]           counter_load_o,
  output bridge_pkg::board_cfg_t    board_cfg_o,
  output logic                      irq_clear_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_CLAIM, ST_XFER, ST_DRAIN, ST_TURN} tgt_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] low_lane(input logic [3:0] be_n);
    if (!be_n[0]) return 2'd0;
    if (!be_n[1]) return 2'd1;
    if (!be_n[2]) return 2'd2;
    if (!be_n[3]) return 2'd3;
    return 2'd0;
  endfunction

  function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] l);
    return d[8 * l +: 8];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tgt_state_t  state_r;
  tgt_state_t  state_nxt;
  logic        frame_q_r;
  logic [31:0] addr_r;
  logic [3:0]  cmd_r;
  logic        sel_cfg_r;
  logic        sel_brg_r;
  logic        sel_brd_r;
  logic [31:0] rdata_r;
  logic        par_r;
  logic        par_oe_r;
  logic [15:0] cmd_reg_r;
  logic [19:0] bar0_r;
  logic [19:0] bar1_r;
  logic [31:0] window_r;
  logic        key_ok_r;
  logic [7:0]  brd_rdata;

  bridge_pkg::board_req_t brd_req;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  wire logic mem_en     = cmd_reg_r[bridge_pkg::CMD_MEM_EN_BIT];
  wire logic addr_phase = state_r == ST_IDLE && !frame_n_i && frame_q_r;
  wire logic is_cfg     = idsel_i && ad_i[1:0] == 2'b00 &&
                          (cbe_n_i == bridge_pkg::CMD_CFG_RD || cbe_n_i == bridge_pkg::CMD_CFG_WR);
  wire logic is_mem     = mem_en &&
                          (cbe_n_i == bridge_pkg::CMD_MEM_RD || cbe_n_i == bridge_pkg::CMD_MEM_WR);
  wire logic hit_brg    = is_mem && ad_i[31:12] == bar0_r;
  wire logic hit_brd    = is_mem && ad_i[31:12] == bar1_r;
  wire logic claim_hit  = is_cfg || hit_brg || hit_brd;

  // ---------------------------------------------------------------
  // data phase decode
  // ---------------------------------------------------------------
  wire logic        xfer_done  = state_r == ST_XFER && !irdy_n_i;
  wire logic        is_write   = cmd_r[0];
  wire logic        full_word  = cbe_n_i == 4'h0;
  wire logic        cfg_wr     = xfer_done && is_write && sel_cfg_r;
  // partial writes to the bridge and the base registers are dropped
  wire logic        brg_wr     = xfer_done && is_write && sel_brg_r && full_word;
  wire logic        bar_wr     = cfg_wr && full_word;
  wire logic [11:0] win_ofs    = addr_r[11:0];
  wire logic        forward_ok = window_r[bridge_pkg::WINDOW_EN_BIT] && key_ok_r;
  wire logic [1:0]  lane       = low_lane(cbe_n_i);

  assign brd_req.wr     = xfer_done && is_write && sel_brd_r && forward_ok;
  assign brd_req.offset = {win_ofs[11:2], lane};
  assign brd_req.wdata  = lane_byte(ad_i, lane);

  logic [31:0] cfg_word;
  always_comb begin
    unique case (addr_r[7:0])
      bridge_pkg::CFG_ID_OFS:   cfg_word = {DEVICE_ID, VENDOR_ID};
      bridge_pkg::CFG_CMD_OFS:  cfg_word = {16'h0000, cmd_reg_r};
      bridge_pkg::CFG_BAR0_OFS: cfg_word = {bar0_r, 12'h000};
      bridge_pkg::CFG_BAR1_OFS: cfg_word = {bar1_r, 12'h000};
      default:                  cfg_word = 32'h00000000;
    endcase
  end

  wire logic [31:0] brg_word = (win_ofs == bridge_pkg::BRG_WINDOW_OFS) ? window_r : 32'h00000000;
  wire logic [31:0] brd_word = forward_ok ? {4{brd_rdata}} : 32'h00000000;
  wire logic [31:0] rd_word  = sel_cfg_r ? cfg_word : sel_brg_r ? brg_word : brd_word;

  // ---------------------------------------------------------------
  // target sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (addr_phase && claim_hit) state_nxt = ST_CLAIM;
      ST_CLAIM: state_nxt = ST_XFER;
      ST_XFER:  if (!irdy_n_i) state_nxt = frame_n_i ? ST_TURN : ST_DRAIN;
      ST_DRAIN: if (frame_n_i) state_nxt = ST_TURN;
      ST_TURN:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r   <= ST_IDLE;
      frame_q_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      frame_q_r <= frame_n_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r    <= 32'h00000000;
      cmd_r     <= 4'h0;
      sel_cfg_r <= 1'b0;
      sel_brg_r <= 1'b0;
      sel_brd_r <= 1'b0;
    end else if (addr_phase) begin
      addr_r    <= ad_i;
      cmd_r     <= cbe_n_i;
      sel_cfg_r <= is_cfg;
      sel_brg_r <= !is_cfg && hit_brg;
      sel_brd_r <= !is_cfg && !hit_brg && hit_brd;
    end
  end

  // read word is latched one cycle before it is driven
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r  <= 32'h00000000;
      par_r    <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      if (state_r == ST_CLAIM) rdata_r <= rd_word;
      par_r    <= ^{ad_o, cbe_n_i};
      par_oe_r <= ad_oe_o;
    end
  end

  // ---------------------------------------------------------------
  // configuration and bridge registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_reg_r <= bridge_pkg::CMD_RESET;
      bar0_r    <= bridge_pkg::BAR_RESET;
      bar1_r    <= bridge_pkg::BAR_RESET;
    end else begin
      if (cfg_wr && addr_r[7:0] == bridge_pkg::CFG_CMD_OFS) begin
        if (!cbe_n_i[0]) cmd_reg_r[7:0]  <= ad_i[7:0];
        if (!cbe_n_i[1]) cmd_reg_r[15:8] <= ad_i[15:8];
      end
      // low 12 bits stay zero so sizing reads back a 4 KB window
      if (bar_wr && addr_r[7:0] == bridge_pkg::CFG_BAR0_OFS)
        bar0_r <= ad_i[31:bridge_pkg::WIN_ADDR_BITS];
      if (bar_wr && addr_r[7:0] == bridge_pkg::CFG_BAR1_OFS)
        bar1_r <= ad_i[31:bridge_pkg::WIN_ADDR_BITS];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      window_r <= bridge_pkg::WINDOW_RESET;
      key_ok_r <= 1'b0;
    end else begin
      if (brg_wr && win_ofs == bridge_pkg::BRG_WINDOW_OFS)
        window_r <= ad_i & (bridge_pkg::WINDOW_ADDR_MASK | bridge_pkg::WINDOW_EN_MASK);
      if (brg_wr && win_ofs == bridge_pkg::BRG_UNLOCK_OFS)
        key_ok_r <= ad_i == bridge_pkg::UNLOCK_KEY;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign ad_o        = rdata_r;
  assign ad_oe_o     = state_r == ST_XFER && !is_write;
  assign devsel_n_o  = !(state_r == ST_CLAIM || state_r == ST_XFER || state_r == ST_DRAIN);
  assign trdy_n_o    = state_r != ST_XFER;
  // burst beyond one word: disconnect together with the first data
  assign stop_n_o    = !((state_r == ST_XFER && !frame_n_i) || state_r == ST_DRAIN);
  assign devsel_oe_o = state_r != ST_IDLE;
  assign trdy_oe_o   = state_r != ST_IDLE;
  assign stop_oe_o   = state_r != ST_IDLE;
  assign par_o       = par_r;
  assign par_oe_o    = par_oe_r;

  board_regs u_board_regs (
    .core_clk_i     (core_clk_i),
    .rstn_i         (rstn_i),
    .req_i          (brd_req),
    .rdata_o        (brd_rdata),
    .port_in_i      (port_in_i),
    .counter_in_i   (counter_in_i),
    .port_out_o     (port_out_o),
    .counter_load_o (counter_load_o),
    .cfg_o          (board_cfg_o),
    .irq_clear_o    (irq_clear_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_bar0_hit;
    addr_phase && !is_cfg && is_mem && ad_i[31:12] == bar0_r;
  endsequence
  sequence s_claim_then_ready;
    !devsel_n_o && trdy_n_o ##1 !devsel_n_o && !trdy_n_o;
  endsequence

  bar0_claim_a: assert property (s_bar0_hit |=> s_claim_then_ready)
    else $error("bridge window hit not claimed");
  bar1_claim_a: assert property (
    addr_phase && !is_cfg && is_mem && ad_i[31:12] == bar1_r && ad_i[31:12] != bar0_r
      |=> sel_brd_r && !devsel_n_o)
    else $error("board window hit not claimed");
  bar_size_a: assert property (
    bar_wr && addr_r[7:0] == bridge_pkg::CFG_BAR1_OFS |=> bar1_r == $past(ad_i[31:12]))
    else $error("board base register not 4 KB aligned");
  id_read_a: assert property (
    state_r == ST_CLAIM && sel_cfg_r && addr_r[7:0] == bridge_pkg::CFG_ID_OFS
      |=> ad_o == {DEVICE_ID, VENDOR_ID} && ad_oe_o == !is_write)
    else $error("identification word wrong");
  window_load_a: assert property (
    brg_wr && win_ofs == bridge_pkg::BRG_WINDOW_OFS
      |=> window_r == ($past(ad_i) & 32'hFFFFFF80))
    else $error("window register load wrong");
  narrow_write_a: assert property (
    xfer_done && is_write && sel_brg_r && !full_word |=> $stable(window_r) && $stable(key_ok_r))
    else $error("partial write changed a bridge register");
  mem_enable_a: assert property (
    addr_phase && !is_cfg && !mem_en |=> devsel_n_o)
    else $error("memory claim while memory space disabled");
  board_gate_a: assert property (
    brd_req.wr |-> window_r[7] && key_ok_r && sel_brd_r)
    else $error("board write forwarded with window closed");
  burst_stop_a: assert property (
    state_r == ST_XFER && !frame_n_i && !irdy_n_i |=> !stop_n_o && trdy_n_o)
    else $error("burst not disconnected");

endmodule // pci_board_window_bridge

`default_nettype wire

//--- pci_host_model.sv
// PCI host model: single-word master cycles toward the bridge.
// Assumes the target drives AD only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
  // bus
  input  wire logic        clk_i,
  input  wire logic [31:0] tgt_ad_i,
  input  wire logic        tgt_oe_i,
  input  wire logic        trdy_n_i,
  output logic [31:0]      ad_o,
  output logic [3:0]       cbe_n_o,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             idsel_o
);
  logic [31:0] drv;
  assign ad_o = tgt_oe_i ? tgt_ad_i : drv;
  initial begin
    drv = 32'h0;
    cbe_n_o = 4'hF;
    frame_n_o = 1'b1;
    irdy_n_o = 1'b1;
    idsel_o = 1'b0;
  end
  // ------------------------------------------------------------
  // one data phase; no trdy within 8 edges counts as unclaimed
  // ------------------------------------------------------------
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic cl);
    int n;
    @(negedge clk_i);
    frame_n_o = 1'b0;
    drv = a;
    cbe_n_o = c;
    idsel_o = c[3];
    @(negedge clk_i);
    frame_n_o = 1'b1;
    irdy_n_o = 1'b0;
    cbe_n_o = be;
    drv = c[0] ? wd : ~a;
    cl = 1'b0;
    rd = 32'h0;
    for (n = 0; n < 8 && !cl; n++) begin
      @(posedge clk_i);
      if (trdy_n_i === 1'b0) begin
        cl = 1'b1;
        rd = ad_o;
      end
    end
    @(negedge clk_i);
    irdy_n_o = 1'b1;
    cbe_n_o = 4'hF;
    idsel_o = 1'b0;
    drv = ~drv;
    repeat (3) @(negedge clk_i);
  endtask
endmodule // pci_host_model
`default_nettype wire

//--- testbench.sv
// Testbench: configures the bridge, opens the board window, walks the map.
// Assumes the host model and the bridge share one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] VID = 16'h3C3C; // arbitrary value
  localparam logic [15:0] DID = 16'h0E1E; // arbitrary value
  logic clk, rstn, toe, tn, toe_t, cl;
  logic [31:0] ad, tad, rd, bar1;
  logic [3:0] cbe_n;
  logic frame_n, irdy_n, idsel, clr, par, par_oe;
  logic [35:0] bus_q;
  logic [11:0][7:0] port_in, port_out;
  logic [1:0][7:0] counter_in, counter_load;
  bridge_pkg::board_cfg_t cfg;
  logic [7:0] b;
  int err_total, check_count, pulses, misses;
  pci_board_window_bridge #(.VENDOR_ID(VID), .DEVICE_ID(DID)) pci_board_window_bridge_inst (
    .core_clk_i(clk), .rstn_i(rstn), .ad_i(ad), .ad_o(tad), .ad_oe_o(toe), .cbe_n_i(cbe_n),
    .frame_n_i(frame_n), .irdy_n_i(irdy_n), .idsel_i(idsel), .devsel_n_o(), .devsel_oe_o(),
    .trdy_n_o(tn), .trdy_oe_o(toe_t), .stop_n_o(), .stop_oe_o(), .par_o(par), .par_oe_o(par_oe),
    .port_in_i(port_in), .counter_in_i(counter_in), .port_out_o(port_out),
    .counter_load_o(counter_load), .board_cfg_o(cfg), .irq_clear_o(clr));
  pci_host_model pci_host_model_inst (.clk_i(clk), .tgt_ad_i(tad), .tgt_oe_i(toe),
    .trdy_n_i(toe_t ? tn : 1'b1), .ad_o(ad), .cbe_n_o(cbe_n), .frame_n_o(frame_n),
    .irdy_n_o(irdy_n), .idsel_o(idsel));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (clr === 1'b1) pulses++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // parity trails read data by one cycle and covers AD and byte enables
  always @(posedge clk) begin
    if (par_oe === 1'b1) chk(32'(par), 32'(^bus_q));
    bus_q <= {ad, cbe_n};
  end
  task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic [31:0] wd);
    pci_host_model_inst.xfer(c, a, 4'h0, wd, rd, cl);
    if (cl !== 1'b1) misses++;
  endtask
  // byte access: lane picked by the low offset bits, data on all lanes
  task automatic bacc(input logic [3:0] c, input logic [11:0] o, input logic [7:0] d);
    pci_host_model_inst.xfer(c, bar1 | {20'h0, o[11:2], 2'b00}, ~(4'h1 << o[1:0]), {4{d}}, rd, cl);
    if (cl !== 1'b1) misses++;
  endtask
  function automatic logic [7:0] obs(input int o);
    if (o < 16) return (o % 4 == 3) ? cfg.iface_mode[o/4] : port_out[3*(o/4)+o%4];
    case (o)
      16, 17: return counter_load[o-16];
      19: return cfg.counter_mode;
      20: return cfg.irq_one;
      default: return cfg.irq_two;
    endcase
  endfunction
  function automatic logic [7:0] rexp(input int o);
    if (o < 16 && o % 4 != 3) return port_in[3*(o/4)+o%4];
    if (o == 16 || o == 17) return counter_in[o-16];
    return 8'h00;
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #5000000;
    err_total++;
    conclude;
  end
  initial begin
    rstn = 1'b0;
    void'($urandom(74));
    for (int i = 0; i < 12; i++) port_in[i] = 8'($urandom);
    counter_in = 16'($urandom);
    bar1 = {4'hE, 16'($urandom), 12'h000};
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    acc(bridge_pkg::CMD_CFG_RD, 32'h0, 32'h0);
    chk(rd, {DID, VID});
    acc(bridge_pkg::CMD_MEM_RD, 32'h0, 32'h0);
    chk(32'(cl), 32'h0);
    acc(bridge_pkg::CMD_CFG_WR, 32'h4, 32'h2);
    acc(bridge_pkg::CMD_CFG_WR, 32'h10, 32'hFFFFFFFF);
    acc(bridge_pkg::CMD_CFG_RD, 32'h10, 32'h0);
    chk(rd, 32'hFFFFF000);
    acc(bridge_pkg::CMD_CFG_WR, 32'h10, 32'h000D0000);
    acc(bridge_pkg::CMD_CFG_WR, 32'h14, bar1);
    acc(bridge_pkg::CMD_CFG_RD, 32'h14, 32'h0);
    chk(rd, bar1);
    $display("config done");
    bacc(bridge_pkg::CMD_MEM_WR, 12'h000, 8'h55);
    chk(32'(port_out[0]), 32'h0);
    acc(bridge_pkg::CMD_MEM_WR, 32'h000D0340, 32'h0000AEAE);
    acc(bridge_pkg::CMD_MEM_WR, 32'h000D00C0, (bar1 & 32'hFFFFFF00) | 32'h00000080);
    acc(bridge_pkg::CMD_MEM_RD, 32'h000D00C0, 32'h0);
    chk(rd, bar1 | 32'h00000080);
    pci_host_model_inst.xfer(bridge_pkg::CMD_MEM_WR, 32'h000D00C0, 4'hE, 32'h0, rd, cl);
    acc(bridge_pkg::CMD_MEM_RD, 32'h000D00C0, 32'h0);
    chk(rd, bar1 | 32'h00000080);
    $display("window done");
    for (int o = 0; o < 22; o++) begin
      if (o == 18) continue;
      b = 8'($urandom);
      bacc(bridge_pkg::CMD_MEM_WR, 12'(o), b);
      chk(32'(obs(o)), 32'(b));
      bacc(bridge_pkg::CMD_MEM_RD, 12'(o), 8'h00);
      chk(rd, {4{rexp(o)}});
    end
    bacc(bridge_pkg::CMD_MEM_WR, 12'h016, 8'($urandom));
    chk(32'(pulses), 32'h1);
    acc(bridge_pkg::CMD_MEM_RD, 32'h00F00000, 32'h0);
    chk(32'(cl), 32'h0);
    chk(32'(misses), 32'h2);
    $display("board map done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
